// ==== design/codec_data_word_format.sv ====
// Purpose: packs and unpacks the 64-bit data-mode word of the codec
// Assumes: format, stereo and bypass come from control-mode logic on sys_clk
// Notes: link side runs on link_clk, settings on sys_clk
//
// Contract
// - left high byte at bits 63..56
// - left low byte at bits 55..48
// - 8-bit formats use high byte, low zeroed
// - right high byte at bits 47..40
// - right low byte bits 39..32, unused 8-bit
// - mono uses left only, right sent zero
// - samples msb first, twos complement linear
// - bits 31,30 enable line outputs 1,0
// - left attenuation bits 29..24, 63 mutes
// - right attenuation bits 21..16, 63 mutes
// - invalid flag bit 23 during calibration
// - bit 22 enables mono speaker
// - bits 15,14 signalling, no codec effect
// - overrange flag bit 13 set on overrange
// - overrange sticky, cleared only by zero
// - input select with microphone bypass
// - left input gain bits 11..8
// - right input gain bits 3..0
// - monitor mix bits 7..4, 15 disables
// - format code selects sample format
// - data-or-control pin selects word meaning
`timescale 1ns/100ps
module codec_data_word_format
  import codec_word_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic link_clk,
  input wire logic frame_sync,
  input wire logic sdata_in,
  output logic sdata_out,
  output logic sdata_oe,
  input wire logic data_mode_pin,
  input wire logic [1:0] sample_format,
  input wire logic stereo_select,
  input wire logic microphone_bypass,
  input wire logic calibrating_pin,
  input wire logic overrange_pin,
  input wire logic [1:0] signalling_in,
  input wire logic [15:0] adc_left,
  input wire logic [15:0] adc_right,
  output logic [15:0] left_dac_sample,
  output logic [15:0] right_dac_sample,
  output logic dac_valid,
  output logic line1_enable,
  output logic line0_enable,
  output logic [5:0] left_dac_atten,
  output logic [5:0] right_dac_atten,
  output logic left_dac_mute,
  output logic right_dac_mute,
  output logic speaker_enable,
  output logic [1:0] signalling_bits,
  output logic overrange_flag,
  output logic input_select,
  output logic mic_level_select,
  output logic [3:0] left_input_gain,
  output logic [3:0] right_input_gain,
  output logic [3:0] monitor_mix_atten,
  output logic monitor_mix_enable
);
  import codec_word_pkg::*;

  typedef struct packed {
    logic mode_s1;
    logic mode_s2;
    logic cal_s1;
    logic cal_s2;
    logic ovr_s1;
    logic ovr_s2;
    logic [1:0] sig_s1;
    logic [1:0] sig_s2;
    logic rxt_s1;
    logic rxt_s2;
    logic rxt_s3;
    logic ack_s1;
    logic ack_s2;
    logic tx_req;
    logic [WORD_W-1:0] tx_hold;
    logic [15:0] left_dac;
    logic [15:0] right_dac;
    logic dac_valid;
    logic line1_en;
    logic line0_en;
    logic [ATTEN_W-1:0] left_atten;
    logic [ATTEN_W-1:0] right_atten;
    logic left_mute;
    logic right_mute;
    logic speaker_en;
    logic [1:0] signal_out;
    logic ovr_flag;
    logic in_sel;
    logic mic_sel;
    logic [GAIN_W-1:0] left_gain;
    logic [GAIN_W-1:0] right_gain;
    logic [GAIN_W-1:0] mix_atten;
    logic mix_en;
  } core_state_t;

  core_state_t s_q, s_d;
  word_link_if lnk ();

  logic word_event;
  logic data_word;
  logic [WORD_W-1:0] rw;
  logic eight_bit;
  logic [7:0] left_hi, left_lo, right_hi, right_lo;
  logic [15:0] rx_left, rx_right;
  logic ovr_clear;
  logic [WORD_W-1:0] tx_build;

  word_link_engine u_engine (
    .link_clk(link_clk),
    .nrst(nrst),
    .frame_sync(frame_sync),
    .sdata_in(sdata_in),
    .sdata_out(sdata_out),
    .sdata_oe(sdata_oe),
    .lnk(lnk)
  );

  always_comb begin
    s_d = s_q;
    // pins from other domains pass two flops first
    s_d.mode_s1 = data_mode_pin;
    s_d.mode_s2 = s_q.mode_s1;
    s_d.cal_s1 = calibrating_pin;
    s_d.cal_s2 = s_q.cal_s1;
    s_d.ovr_s1 = overrange_pin;
    s_d.ovr_s2 = s_q.ovr_s1;
    s_d.sig_s1 = signalling_in;
    s_d.sig_s2 = s_q.sig_s1;
    s_d.rxt_s1 = lnk.rx_tgl;
    s_d.rxt_s2 = s_q.rxt_s1;
    s_d.rxt_s3 = s_q.rxt_s2;
    s_d.ack_s1 = lnk.tx_ack;
    s_d.ack_s2 = s_q.ack_s1;
    s_d.dac_valid = 1'b0;

    // rx_word is held still for a whole word, so it is safe after sync
    word_event = s_q.rxt_s2 ^ s_q.rxt_s3;
    data_word = word_event & s_q.mode_s2;
    rw = lnk.rx_word;

    unique case (sample_format_t'(sample_format))
      FMT_LINEAR16: eight_bit = 1'b0;
      FMT_MULAW8: eight_bit = 1'b1;
      FMT_ALAW8: eight_bit = 1'b1;
      FMT_LINEAR8: eight_bit = 1'b1;
    endcase

    left_hi = rw[LEFT_HI_POS +: 8];
    left_lo = rw[LEFT_LO_POS +: 8];
    right_hi = rw[RIGHT_HI_POS +: 8];
    right_lo = rw[RIGHT_LO_POS +: 8];

    rx_left = eight_bit ? {left_hi, 8'h00} : {left_hi, left_lo};
    rx_right = eight_bit ? {right_hi, 8'h00} : {right_hi, right_lo};
    if (!stereo_select) begin
      rx_right = rx_left;
    end

    ovr_clear = data_word & ~rw[OVERRANGE_POS];
    s_d.ovr_flag = s_q.ovr_s2 | (s_q.ovr_flag & ~ovr_clear);

    if (data_word) begin
      s_d.left_dac = rx_left;
      s_d.right_dac = rx_right;
      s_d.dac_valid = 1'b1;
      s_d.line1_en = rw[LINE1_POS];
      s_d.line0_en = rw[LINE0_POS];
      s_d.left_atten = rw[LEFT_ATTEN_POS +: ATTEN_W];
      s_d.left_mute = (rw[LEFT_ATTEN_POS +: ATTEN_W] == ATTEN_MUTE_CODE);
      s_d.right_atten = rw[RIGHT_ATTEN_POS +: ATTEN_W];
      s_d.right_mute = (rw[RIGHT_ATTEN_POS +: ATTEN_W] == ATTEN_MUTE_CODE);
      s_d.speaker_en = rw[SPEAKER_POS];
      s_d.signal_out = rw[SIGNAL_POS +: 2];
      s_d.in_sel = rw[INSEL_POS];
      s_d.left_gain = rw[LEFT_GAIN_POS +: GAIN_W];
      s_d.mix_atten = rw[MIX_POS +: GAIN_W];
      s_d.mix_en = (rw[MIX_POS +: GAIN_W] != MIX_OFF_CODE);
      s_d.right_gain = rw[RIGHT_GAIN_POS +: GAIN_W];
      // reserved byte needs nothing more; its bits are the fields above
    end

    // bypass steers mic level
    // registered select, one cycle behind input_select
    s_d.mic_sel = s_q.in_sel & ~microphone_bypass;

    // transmit word from current state
    tx_build = '0;
    tx_build[LEFT_HI_POS +: 8] = adc_left[15:8];
    tx_build[LEFT_LO_POS +: 8] = eight_bit ? 8'h00 : adc_left[7:0];
    if (stereo_select) begin
      tx_build[RIGHT_HI_POS +: 8] = adc_right[15:8];
      tx_build[RIGHT_LO_POS +: 8] = eight_bit ? 8'h00 : adc_right[7:0];
    end
    tx_build[LINE1_POS] = s_q.line1_en;
    tx_build[LINE0_POS] = s_q.line0_en;
    tx_build[LEFT_ATTEN_POS +: ATTEN_W] = s_q.left_atten;
    tx_build[INVALID_POS] = s_q.cal_s2;
    tx_build[SPEAKER_POS] = s_q.speaker_en;
    tx_build[RIGHT_ATTEN_POS +: ATTEN_W] = s_q.right_atten;
    tx_build[SIGNAL_POS +: 2] = s_q.sig_s2;
    tx_build[OVERRANGE_POS] = s_q.ovr_flag;
    tx_build[INSEL_POS] = s_q.in_sel;
    tx_build[LEFT_GAIN_POS +: GAIN_W] = s_q.left_gain;
    tx_build[MIX_POS +: GAIN_W] = s_q.mix_atten;
    tx_build[RIGHT_GAIN_POS +: GAIN_W] = s_q.right_gain;

    // handshake: new word only once the link took the last one
    if (s_q.ack_s2 == s_q.tx_req) begin
      s_d.tx_hold = tx_build;
      s_d.tx_req = ~s_q.tx_req;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.line1_en <= RST_LINE_EN;
      s_q.line0_en <= RST_LINE_EN;
      s_q.left_atten <= RST_ATTEN;
      s_q.right_atten <= RST_ATTEN;
      s_q.left_mute <= RST_MUTE;
      s_q.right_mute <= RST_MUTE;
      s_q.speaker_en <= RST_SPEAKER;
      s_q.signal_out <= RST_SIGNAL;
      s_q.ovr_flag <= RST_OVERRANGE;
      s_q.in_sel <= RST_INSEL;
      s_q.left_gain <= RST_GAIN;
      s_q.right_gain <= RST_GAIN;
      s_q.mix_atten <= RST_MIX;
      s_q.mix_en <= RST_MIX_EN;
    end else begin
      s_q <= s_d;
    end
  end

  assign lnk.tx_word = s_q.tx_hold;
  assign lnk.tx_req = s_q.tx_req;

  assign left_dac_sample = s_q.left_dac;
  assign right_dac_sample = s_q.right_dac;
  assign dac_valid = s_q.dac_valid;
  assign line1_enable = s_q.line1_en;
  assign line0_enable = s_q.line0_en;
  assign left_dac_atten = s_q.left_atten;
  assign right_dac_atten = s_q.right_atten;
  assign left_dac_mute = s_q.left_mute;
  assign right_dac_mute = s_q.right_mute;
  assign speaker_enable = s_q.speaker_en;
  assign signalling_bits = s_q.signal_out;
  assign overrange_flag = s_q.ovr_flag;
  assign input_select = s_q.in_sel;
  assign mic_level_select = s_q.mic_sel;
  assign left_input_gain = s_q.left_gain;
  assign right_input_gain = s_q.right_gain;
  assign monitor_mix_atten = s_q.mix_atten;
  assign monitor_mix_enable = s_q.mix_en;
endmodule : codec_data_word_format

// ==== design/codec_word_pkg.sv ====
// Purpose: shared constants for the 64-bit data-mode word packer
// Assumes: word bit 63 is shifted first
// Notes: defaults are the values held after reset
package codec_word_pkg;
  localparam int WORD_W = 64;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] CNT_FIRST = 6'h01;
  localparam logic [CNT_W-1:0] CNT_LAST = 6'h3F;
  // bit positions and widths of the word fields
  localparam int LEFT_HI_POS = 56;
  localparam int LEFT_LO_POS = 48;
  localparam int RIGHT_HI_POS = 40;
  localparam int RIGHT_LO_POS = 32;
  localparam int LINE1_POS = 31;
  localparam int LINE0_POS = 30;
  localparam int LEFT_ATTEN_POS = 24;
  localparam int INVALID_POS = 23;
  localparam int SPEAKER_POS = 22;
  localparam int RIGHT_ATTEN_POS = 16;
  localparam int SIGNAL_POS = 14;
  localparam int OVERRANGE_POS = 13;
  localparam int INSEL_POS = 12;
  localparam int LEFT_GAIN_POS = 8;
  localparam int MIX_POS = 4;
  localparam int RIGHT_GAIN_POS = 0;
  localparam int ATTEN_W = 6;
  localparam int GAIN_W = 4;
  // sample format codes
  typedef enum logic [1:0] {
    FMT_LINEAR16 = 2'h0,
    FMT_MULAW8 = 2'h1,
    FMT_ALAW8 = 2'h2,
    FMT_LINEAR8 = 2'h3
  } sample_format_t;
  localparam logic [ATTEN_W-1:0] ATTEN_MUTE_CODE = 6'h3F;
  localparam logic [GAIN_W-1:0] MIX_OFF_CODE = 4'hF;
  // values after reset
  localparam logic RST_LINE_EN = 1'h0;
  localparam logic [ATTEN_W-1:0] RST_ATTEN = 6'h3F;
  localparam logic RST_SPEAKER = 1'h0;
  localparam logic RST_INSEL = 1'h0;
  localparam logic [GAIN_W-1:0] RST_GAIN = 4'h0;
  localparam logic [GAIN_W-1:0] RST_MIX = 4'hF;
  localparam logic [1:0] RST_SIGNAL = 2'h3;
  localparam logic RST_OVERRANGE = 1'h0;
  localparam logic RST_MUTE = 1'h1;
  localparam logic RST_MIX_EN = 1'h0;
endpackage : codec_word_pkg

// ==== design/word_link_if.sv ====
// Purpose: carries words between the link engine and the settings core
// Assumes: toggles mark events, words stay still until acknowledged
// Notes: rx_word is stable for a whole word after rx_tgl flips
`timescale 1ns/100ps
interface word_link_if;
  logic [63:0] rx_word;
  logic rx_tgl;
  logic [63:0] tx_word;
  logic tx_req;
  logic tx_ack;
  modport engine (
    output rx_word,
    output rx_tgl,
    input tx_word,
    input tx_req,
    output tx_ack
  );
  modport core (
    input rx_word,
    input rx_tgl,
    output tx_word,
    output tx_req,
    input tx_ack
  );
endinterface : word_link_if

// ==== design/word_link_engine.sv ====
// Purpose: shifts one 64-bit word in and out on the link clock
// Assumes: frame_sync is high during the first bit, synchronous to link_clk
// Notes: each output bit is launched on the same link clock edge that samples the matching input bit
`timescale 1ns/100ps
module word_link_engine
  import codec_word_pkg::*;
(
  input wire logic link_clk,
  input wire logic nrst,
  input wire logic frame_sync,
  input wire logic sdata_in,
  output logic sdata_out,
  output logic sdata_oe,
  word_link_if.engine lnk
);
  typedef struct packed {
    logic active;
    logic [CNT_W-1:0] cnt;
    logic [WORD_W-1:0] rx_sh;
    logic [WORD_W-1:0] rx_word;
    logic rx_tgl;
    logic out;
    logic oe;
    logic [WORD_W-2:0] tx_sh;
    logic [WORD_W-1:0] tx_buf;
    logic req_s1;
    logic req_s2;
    logic ack;
  } eng_state_t;

  eng_state_t s_q, s_d;
  logic [WORD_W-1:0] tx_src;

  always_comb begin
    s_d = s_q;
    s_d.req_s1 = lnk.tx_req;
    s_d.req_s2 = s_q.req_s1;
    tx_src = (s_q.req_s2 != s_q.ack) ? lnk.tx_word : s_q.tx_buf;
    s_d.oe = frame_sync | s_q.active;
    if (frame_sync) begin
      s_d.active = 1'b1;
      s_d.cnt = CNT_FIRST;
      s_d.rx_sh = {s_q.rx_sh[WORD_W-2:0], sdata_in};
      s_d.out = tx_src[WORD_W-1];
      s_d.tx_sh = tx_src[WORD_W-2:0];
      s_d.tx_buf = tx_src;
      s_d.ack = s_q.req_s2;
    end else if (s_q.active) begin
      s_d.rx_sh = {s_q.rx_sh[WORD_W-2:0], sdata_in};
      s_d.out = s_q.tx_sh[WORD_W-2];
      s_d.tx_sh = {s_q.tx_sh[WORD_W-3:0], 1'b0};
      s_d.cnt = s_q.cnt + 6'h01;
      if (s_q.cnt == CNT_LAST) begin
        s_d.active = 1'b0;
        s_d.rx_word = {s_q.rx_sh[WORD_W-2:0], sdata_in};
        s_d.rx_tgl = ~s_q.rx_tgl;
      end
    end
  end

  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign lnk.rx_word = s_q.rx_word;
  assign lnk.rx_tgl = s_q.rx_tgl;
  assign lnk.tx_ack = s_q.ack;
  assign sdata_out = s_q.out;
  assign sdata_oe = s_q.oe;
endmodule : word_link_engine

// ==== testbench/word_format_props.sv ====
// Purpose: port assertions for the word packer
// Assumes: bound to codec_data_word_format
// Notes: settings move only with dac_valid
`timescale 1ns/100ps
module word_format_props
  import codec_word_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic link_clk,
  input wire logic frame_sync,
  input wire logic sdata_oe,
  input wire logic microphone_bypass,
  input wire logic overrange_pin,
  input wire logic dac_valid,
  input wire logic line1_enable,
  input wire logic [5:0] left_dac_atten,
  input wire logic left_dac_mute,
  input wire logic overrange_flag,
  input wire logic input_select,
  input wire logic mic_level_select,
  input wire logic [3:0] left_input_gain,
  input wire logic [3:0] monitor_mix_atten,
  input wire logic monitor_mix_enable
);
  AST_LEFT_MUTE: assert property (@(posedge sys_clk) disable iff (!nrst)
    left_dac_mute == (left_dac_atten == ATTEN_MUTE_CODE)) else $error("left mute wrong");
  AST_MIX_ENABLE: assert property (@(posedge sys_clk) disable iff (!nrst)
    monitor_mix_enable == (monitor_mix_atten != MIX_OFF_CODE)) else $error("mix enable wrong");
  AST_MIC_LEVEL: assert property (@(posedge sys_clk) disable iff (!nrst)
    mic_level_select == $past(input_select && !microphone_bypass)) else $error("mic level wrong");
  AST_WHOLE_WORD: assert property (@(posedge sys_clk) disable iff (!nrst)
    $changed({line1_enable, left_dac_atten, input_select, left_input_gain, monitor_mix_atten}) |-> dac_valid)
    else $error("setting moved outside a word");
  AST_VALID_PULSE: assert property (@(posedge sys_clk) disable iff (!nrst)
    dac_valid |=> !dac_valid) else $error("valid too long");
  AST_OVR_SET: assert property (@(posedge sys_clk) disable iff (!nrst)
    overrange_pin [*4] |=> overrange_flag) else $error("overrange not set");
  AST_OVR_STICKY: assert property (@(posedge sys_clk) disable iff (!nrst)
    $fell(overrange_flag) |-> dac_valid) else $error("overrange dropped alone");
  AST_OE_START: assert property (@(posedge link_clk) disable iff (!nrst)
    frame_sync |=> sdata_oe) else $error("output not enabled");
  AST_OE_END: assert property (@(posedge link_clk) disable iff (!nrst)
    frame_sync |-> ##65 (!sdata_oe || $past(frame_sync))) else $error("output enable length wrong");
endmodule : word_format_props

bind codec_data_word_format word_format_props u_word_format_props (.*);

// ==== testbench/host_link_model.sv ====
// Purpose: host serial port framing 64-bit words
// Assumes: frame_sync marks bit 63
// Notes: link clock runs only inside frames
`timescale 1ns/100ps
module host_link_model (
  output logic link_clk,
  output logic frame_sync,
  output logic sdata_in,
  input wire logic sdata_out
);
  initial begin
    link_clk = 1'b0;
    frame_sync = 1'b0;
    sdata_in = 1'b0;
  end
  task automatic xfer(input logic [63:0] tx, input int n, output logic [63:0] rx);
    int i;
    rx = '0;
    for (i = 0; i < n; i++) begin
      frame_sync = (i == 0);
      // released line must not keep its level
      sdata_in = (i < 64) ? tx[63-i] : ~sdata_in;
      #32 link_clk = 1'b1;
      #32 link_clk = 1'b0;
      // sampled on the falling edge, after the launching edge settled
      if (i < 64) rx[63-i] = sdata_out;
    end
  endtask : xfer
endmodule : host_link_model

// ==== testbench/codec_data_word_format_bench.sv ====
// Purpose: self-checking bench for the word packer
// Assumes: readback needs a second frame
// Notes: outputs sampled on falling edges
`timescale 1ns/100ps
module codec_data_word_format_bench;
  import codec_word_pkg::*;
  logic sys_clk, nrst, link_clk, frame_sync, sdata_in, sdata_out, sdata_oe, data_mode_pin;
  logic stereo_select, microphone_bypass, calibrating_pin, overrange_pin, dac_valid;
  logic [1:0] sample_format, signalling_in, signalling_bits;
  logic [15:0] adc_left, adc_right, left_dac_sample, right_dac_sample;
  logic line1_enable, line0_enable, left_dac_mute, right_dac_mute, speaker_enable;
  logic overrange_flag, input_select, mic_level_select, monitor_mix_enable;
  logic [5:0] left_dac_atten, right_dac_atten;
  logic [3:0] left_input_gain, right_input_gain, monitor_mix_atten;
  logic [63:0] rxw;
  int mismatches, checked, cycles, pulses;
  codec_data_word_format u_codec_data_word_format (.*);
  host_link_model u_host_link_model (.*);
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk) begin
    if (dac_valid === 1'b1) pulses++;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask : check
  function automatic logic [30:0] knobs();
    return {line1_enable, line0_enable, left_dac_atten, speaker_enable, right_dac_atten, signalling_bits,
      overrange_flag, input_select, left_input_gain, monitor_mix_atten, right_input_gain};
  endfunction : knobs
  task automatic send(input logic [63:0] w);
    u_host_link_model.xfer(w, 67, rxw);
    repeat (6) @(negedge sys_clk);
  endtask : send
  task automatic test_reset();
    logic [30:0] e;
    e = {RST_LINE_EN, RST_LINE_EN, RST_ATTEN, RST_SPEAKER, RST_ATTEN, RST_SIGNAL, RST_OVERRANGE, RST_INSEL,
      RST_GAIN, RST_MIX, RST_GAIN};
    check(knobs(), e);
    check({left_dac_mute, right_dac_mute, monitor_mix_enable}, 3'h6);
    $display("test_reset done");
  endtask : test_reset
  task automatic test_settings();
    logic [63:0] w [3];
    int i;
    w = '{64'h7FFF_8001_FFFF_FFFF, 64'h8000_7FFE_0000_0000, 64'h1234_ABCD_9A5C_D6E1};
    for (i = 0; i < 3; i++) begin
      pulses = 0;
      @(posedge sys_clk);
      microphone_bypass <= i[0];
      send(w[i]);
      check(pulses, 1);
      check({left_dac_sample, right_dac_sample}, w[i][63:32]);
      check(knobs(), {w[i][31:24], w[i][22:14], 1'b0, w[i][12:0]});
      check(mic_level_select, w[i][12] & ~i[0]);
      check({left_dac_mute, right_dac_mute, monitor_mix_enable}, {w[i][29:24] == ATTEN_MUTE_CODE,
        w[i][21:16] == ATTEN_MUTE_CODE, w[i][7:4] != MIX_OFF_CODE});
    end
    $display("test_settings done");
  endtask : test_settings
  task automatic test_formats();
    logic [63:0] w;
    logic [15:0] l, r, tl, tr;
    int f, s;
    w = 64'hC381_7E24_0000_0000;
    for (f = 0; f < 4; f++) for (s = 0; s < 2; s++) begin
      @(posedge sys_clk);
      sample_format <= f[1:0];
      stereo_select <= s[0];
      send(w);
      send(w);
      l = f ? {w[63:56], 8'h00} : w[63:48];
      r = !s ? l : f ? {w[47:40], 8'h00} : w[47:32];
      tl = f ? {adc_left[15:8], 8'h00} : adc_left;
      tr = !s ? 16'h0000 : f ? {adc_right[15:8], 8'h00} : adc_right;
      check({left_dac_sample, right_dac_sample}, {l, r});
      check(rxw[63:32], {tl, tr});
    end
    $display("test_formats done");
  endtask : test_formats
  task automatic test_status();
    logic [30:0] keep;
    @(posedge sys_clk);
    calibrating_pin <= 1'b1;
    signalling_in <= 2'h2;
    overrange_pin <= 1'b1;
    repeat (8) @(posedge sys_clk);
    overrange_pin <= 1'b0;
    send(64'h0000_0000_0000_2000);
    check(overrange_flag, 1'b1);
    send(64'h0000_0000_0000_2000);
    check({rxw[23], rxw[15:13]}, 4'hD);
    send(64'h0000_0000_0000_0000);
    check(overrange_flag, 1'b0);
    keep = knobs();
    pulses = 0;
    @(posedge sys_clk);
    data_mode_pin <= 1'b0;
    repeat (4) @(posedge sys_clk);
    send(64'hFFFF_FFFF_FFFF_DF00);
    check(knobs(), keep);
    check(pulses, 0);
    $display("test_status done");
  endtask : test_status
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  initial begin
    nrst = 1'b0;
    data_mode_pin = 1'b1;
    sample_format = 2'h0;
    stereo_select = 1'b1;
    microphone_bypass = 1'b0;
    calibrating_pin = 1'b0;
    overrange_pin = 1'b0;
    signalling_in = 2'h1;
    adc_left = 16'hA55A;
    adc_right = 16'h3CC3;
    // link edges during reset
    fork
      u_host_link_model.xfer(64'h0, 8, rxw);
    join_none
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    @(negedge sys_clk);
    test_reset();
    test_settings();
    test_formats();
    test_status();
    tally_and_finish();
  end
endmodule : codec_data_word_format_bench
